// [hdl/uub_pkg.sv]
// package: register map, defaults and frame codes
`default_nettype none
package uub_pkg;
	localparam int unsigned UUB_CLK_HZ = 50_000_000;
	localparam int unsigned UUB_CNT_W  = 17;
	// register byte offsets
	localparam logic [7:0] UUB_OFF_CTRL  = 8'h00;
	localparam logic [7:0] UUB_OFF_BAUD  = 8'h04;
	localparam logic [7:0] UUB_OFF_STAT  = 8'h08;
	localparam logic [7:0] UUB_OFF_DADDR = 8'h0C;
	localparam logic [7:0] UUB_OFF_DDATA = 8'h10;
	localparam logic [7:0] UUB_OFF_LOCK  = 8'h14;
	localparam logic [7:0] UUB_OFF_MODEM = 8'h18;
	// control field positions and reset values
	localparam int unsigned UUB_DBITS_LSB = 0;
	localparam int unsigned UUB_STOP_LSB  = 2;
	localparam int unsigned UUB_PAR_LSB   = 4;
	localparam int unsigned UUB_FLOW_LSB  = 7;
	localparam int unsigned UUB_DTR_BIT   = 9;
	localparam logic [1:0] UUB_DBITS_RST = 2'h3;
	localparam logic [1:0] UUB_DB5       = 2'h0;
	localparam logic [1:0] UUB_DB7       = 2'h2;
	localparam logic [1:0] UUB_STOP_1    = 2'h0;
	localparam logic [1:0] UUB_STOP_1P5  = 2'h1;
	localparam logic [1:0] UUB_STOP_2    = 2'h2;
	localparam logic [2:0] UUB_PAR_NONE  = 3'h0;
	localparam logic [2:0] UUB_PAR_ODD   = 3'h1;
	localparam logic [2:0] UUB_PAR_EVEN  = 3'h2;
	localparam logic [2:0] UUB_PAR_MARK  = 3'h3;
	localparam logic [2:0] UUB_PAR_SPACE = 3'h4;
	localparam logic [1:0] UUB_FLOW_NONE = 2'h0;
	localparam logic [1:0] UUB_FLOW_RTS  = 2'h1;
	localparam logic [1:0] UUB_FLOW_DTR  = 2'h2;
	localparam logic [1:0] UUB_FLOW_XON  = 2'h3;
	// flow characters and lock key
	localparam logic [7:0] UUB_XON      = 8'h11;
	localparam logic [7:0] UUB_XOFF     = 8'h13;
	localparam logic [7:0] UUB_LOCK_KEY = 8'hA5;
	// descriptor store layout and defaults
	localparam logic [7:0]  UUB_DESC_MAKER    = 8'h00;
	localparam logic [7:0]  UUB_DESC_PRODUCT  = 8'h01;
	localparam logic [7:0]  UUB_DESC_PWR_ATTR = 8'h02;
	localparam logic [7:0]  UUB_DESC_MAX_PWR  = 8'h03;
	localparam logic [7:0]  UUB_DESC_RELEASE  = 8'h04;
	localparam logic [7:0]  UUB_DESC_SER_LEN  = 8'h05;
	localparam logic [7:0]  UUB_DESC_PROD_LEN = 8'h06;
	localparam logic [7:0]  UUB_DESC_SER_BASE = 8'h40;
	localparam logic [7:0]  UUB_DESC_PROD_BASE = 8'h80;
	localparam logic [15:0] UUB_SER_MAX       = 16'h003F;
	localparam logic [15:0] UUB_PROD_MAX      = 16'h007E;
	localparam logic [15:0] UUB_PWR_ATTR_DEF  = 16'h0080;
	localparam logic [15:0] UUB_MAX_PWR_DEF   = 16'h0032;
	localparam logic [15:0] UUB_RELEASE_DEF   = 16'h0100;
	localparam logic [15:0] UUB_SER_LEN_DEF   = 16'h0004;
	localparam logic [15:0] UUB_CHAR_0        = 16'h0030;
	localparam logic [15:0] UUB_CHAR_1        = 16'h0031;
	// bit rates; index 8 is 9600
	localparam int unsigned UUB_NUM_RATES = 29;
	localparam logic [4:0]  UUB_BAUD_RST  = 5'h08;
	localparam logic [4:0]  UUB_BAUD_TOP  = 5'h1C;
	localparam int unsigned UUB_RATES [UUB_NUM_RATES] = '{300, 600, 1200, 1800, 2400, 4000,
		4800, 7200, 9600, 14400, 16000, 19200, 28800, 38400, 51200, 56000, 57600, 64000,
		76800, 115200, 128000, 153600, 230400, 250000, 256000, 460800, 500000, 576000, 921600};
	typedef enum logic [2:0] {UUB_IDLE, UUB_START, UUB_DATA, UUB_PAR, UUB_STOP} uub_fsm_t;
	// clock cycles in half a bit time
	function automatic int unsigned uub_half_cnt(input int unsigned idx);
		uub_half_cnt = UUB_CLK_HZ / (2 * UUB_RATES[idx]);
	endfunction
endpackage
`default_nettype wire

// [hdl/uub_desc_mem.sv]
// module: descriptor store memory
`default_nettype none
module uub_desc_mem
#(
	parameter int unsigned AW = 8,
	parameter int unsigned DW = 16
)
(
	input  wire logic          clk_i,
	input  wire logic          ce_i,
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wr_data_i,
	output logic      [DW-1:0] rd_data_o
);
	logic [DW-1:0] mem_q [2**AW];

	// one port, read data registered
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (wr_en_i)
				mem_q[addr_i] <= wr_data_i;
			rd_data_o <= mem_q[addr_i];
		end
	end
endmodule
`default_nettype wire

// [hdl/uub_bridge.sv]
// top: usb-to-serial bridge control
//
// The APB register port and the placing of the registers were left to the implementer.
`default_nettype none
// Operation
// - data moves between usb and serial, except received xon/xoff codes under xon/xoff flow
// - host commands set serial format and rate
// - suspend detected asserts both low-power indicators
// - indicators stay asserted after reset until configured
// - resume, bus reset or device reset end suspend
// - leaving suspend deasserts both indicators if configured
// - indicators are complementary, one high one low
// - rts/cts, dtr/dsr and xon/xoff flow control
// - modem handshake lines are all active low
// - 5 to 8 data bits, 1.5 stop only 5
// - parity none, even, odd, mark or space
// - standard rates from 300 to 921600 bps
// - top rate needs 7 or 8 data bits
// - unprogrammed store shows default descriptors
// - serial max 63, product max 126, default 0001
// - host writes the descriptor store over apb
// - locked descriptors refuse every later write
module uub_bridge
	import uub_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE   = 16'h1234, // arbitrary value
	parameter logic [15:0] PRODUCT_CODE = 16'h5678, // arbitrary value
	parameter int unsigned BAUD_INIT    = 8
)
(
	input  wire logic        REF_CLK_I,
	input  wire logic        SYS_RST_I,
	input  wire logic        CE_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [11:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        USB_SUSPEND_DET_I,
	input  wire logic        USB_RESUME_I,
	input  wire logic        USB_BUS_RESET_I,
	input  wire logic        USB_CONFIGURED_I,
	input  wire logic [7:0]  USB_OUT_DATA_I,
	input  wire logic        USB_OUT_VALID_I,
	output logic             USB_OUT_READY_O,
	output logic      [7:0]  USB_IN_DATA_O,
	output logic             USB_IN_VALID_O,
	input  wire logic        USB_IN_READY_I,
	output logic             TXD_O,
	input  wire logic        RXD_I,
	input  wire logic        CTS_N_I,
	output logic             RTS_N_O,
	input  wire logic        DSR_N_I,
	output logic             DTR_N_O,
	input  wire logic        DCD_N_I,
	input  wire logic        RI_N_I,
	output logic             SUSPEND_O,
	output logic             SUSPEND_N_O
);
	if (BAUD_INIT >= UUB_NUM_RATES)
	begin : g_chk
		$error("BAUD_INIT outside the rate table");
	end

	logic [1:0]           dbits_q, stop_q, flow_q;
	logic [2:0]           par_q;
	logic                 dtr_q;
	logic [4:0]           baud_q;
	logic [7:0]           daddr_q;
	logic                 locked_q, prog_q, cfg_q, susp_q, xoff_q;
	logic                 err_lock_q, err_fmt_q, err_par_q, err_ovr_q;
	logic                 rd_done_q, rx_full_q;
	logic [31:0]          rd_mux;
	logic [7:0]           rx_data_q, rx_byte, off;
	logic                 acc, done, wr, mapped, fmt_bad, lock_bad, par_bad, ovr;
	logic                 dwr, low_pwr, tx_take, hold, rx_end, rx_ctl, rx_deliver, stat_wr;
	logic [15:0]          mem_rd;
	logic [3:0]           nbits;
	logic [2:0]           stop_halves;
	logic [UUB_CNT_W-1:0] half;
	logic [UUB_CNT_W-1:0] half_tab [UUB_NUM_RATES];
	uub_fsm_t             tx_st_q, rx_st_q;
	logic [7:0]           tx_sh_q, rx_sh_q;
	logic                 tx_par_q;
	logic [2:0]           tx_bit_q, rx_bit_q, tx_hlf_q, rx_hlf_q;
	logic [UUB_CNT_W-1:0] tx_cnt_q, rx_cnt_q;

	// frame legality
	function automatic logic fmt_ok(input logic [1:0] db, input logic [1:0] st,
		input logic [2:0] pa, input logic [4:0] bd);
		fmt_ok = (st != 2'h3) && !(st == UUB_STOP_1P5 && db != UUB_DB5)
			&& (pa <= UUB_PAR_SPACE) && (bd <= UUB_BAUD_TOP)
			&& !(bd == UUB_BAUD_TOP && db < UUB_DB7);
	endfunction

	// parity over the active data bits
	function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
		input logic [2:0] mode);
		logic [7:0] m;
		m = d & (8'hFF >> (4'h8 - n));
		case (mode)
			UUB_PAR_ODD:  par_bit = ~^m;
			UUB_PAR_EVEN: par_bit = ^m;
			UUB_PAR_MARK: par_bit = 1'b1;
			default:      par_bit = 1'b0;
		endcase
	endfunction

	// descriptor address and length limits
	function automatic logic desc_ok(input logic [7:0] a, input logic [15:0] d);
		desc_ok = (a <= UUB_DESC_PROD_LEN && !(a == UUB_DESC_SER_LEN && d > UUB_SER_MAX)
			&& !(a == UUB_DESC_PROD_LEN && d > UUB_PROD_MAX))
			|| (a >= UUB_DESC_SER_BASE && a < UUB_DESC_SER_BASE + UUB_SER_MAX[7:0])
			|| (a >= UUB_DESC_PROD_BASE && a < UUB_DESC_PROD_BASE + UUB_PROD_MAX[7:0]);
	endfunction

	// unprogrammed store defaults
	function automatic logic [15:0] desc_default(input logic [7:0] a);
		case (a)
			UUB_DESC_MAKER:            desc_default = MAKER_CODE;
			UUB_DESC_PRODUCT:          desc_default = PRODUCT_CODE;
			UUB_DESC_PWR_ATTR:         desc_default = UUB_PWR_ATTR_DEF;
			UUB_DESC_MAX_PWR:          desc_default = UUB_MAX_PWR_DEF;
			UUB_DESC_RELEASE:          desc_default = UUB_RELEASE_DEF;
			UUB_DESC_SER_LEN:          desc_default = UUB_SER_LEN_DEF;
			UUB_DESC_SER_BASE + 8'h03: desc_default = UUB_CHAR_1;
			UUB_DESC_SER_BASE,
			UUB_DESC_SER_BASE + 8'h01,
			UUB_DESC_SER_BASE + 8'h02: desc_default = UUB_CHAR_0;
			default:                   desc_default = 16'h0000;
		endcase
	endfunction

	// half-bit counts per rate
	for (genvar g = 0; g < UUB_NUM_RATES; g++)
	begin : g_rate
		assign half_tab[g] = UUB_CNT_W'(uub_half_cnt(g));
	end

	assign half        = half_tab[baud_q];
	assign nbits       = 4'h5 + {2'b00, dbits_q};
	assign stop_halves = 3'h2 + {1'b0, stop_q};

	// apb handshake: writes answer at once, reads after one wait cycle
	assign off       = PADDR_I[7:0];
	assign acc       = PSEL_I & PENABLE_I & CE_I;
	assign PREADY_O  = CE_I & (PWRITE_I | rd_done_q);
	assign done      = acc & PREADY_O;
	assign wr        = done & PWRITE_I & mapped;
	assign PSLVERR_O = done & ~mapped;
	assign stat_wr   = wr & off == UUB_OFF_STAT;

	// read mux and address decode
	always_comb
	begin
		mapped = (PADDR_I[11:8] == 4'h0);
		rd_mux = 32'h0000_0000;
		case (off)
			UUB_OFF_CTRL:  rd_mux = {22'h0, dtr_q, flow_q, par_q, stop_q, dbits_q};
			UUB_OFF_BAUD:  rd_mux = {27'h0, baud_q};
			UUB_OFF_STAT:  rd_mux = {21'h0, err_ovr_q, err_par_q, err_fmt_q, err_lock_q,
				rx_full_q, tx_st_q != UUB_IDLE, xoff_q, prog_q, locked_q, cfg_q, susp_q};
			UUB_OFF_DADDR: rd_mux = {24'h0, daddr_q};
			UUB_OFF_DDATA: rd_mux = {16'h0, prog_q ? mem_rd : desc_default(daddr_q)};
			UUB_OFF_LOCK:  rd_mux = {31'h0, locked_q};
			UUB_OFF_MODEM: rd_mux = {28'h0, ~RI_N_I, ~DCD_N_I, ~DSR_N_I, ~CTS_N_I};
			default:       mapped = 1'b0;
		endcase
	end

	// read capture on the first access cycle
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			rd_done_q <= 1'b0;
			PRDATA_O  <= 32'h0000_0000;
		end
		else if (CE_I)
		begin
			if (done)
				rd_done_q <= 1'b0;
			else if (acc & ~PWRITE_I)
			begin
				rd_done_q <= 1'b1;
				PRDATA_O  <= rd_mux;
			end
		end
	end

	// serial format and rate, rejected as a whole when illegal
	assign fmt_bad = (wr & off == UUB_OFF_CTRL & ~fmt_ok(PWDATA_I[1:0], PWDATA_I[3:2],
		PWDATA_I[6:4], baud_q)) | (wr & off == UUB_OFF_BAUD & ~fmt_ok(dbits_q, stop_q,
		par_q, PWDATA_I[4:0])) | (wr & off == UUB_OFF_DDATA & ~locked_q
		& ~desc_ok(daddr_q, PWDATA_I[15:0]));
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			dbits_q <= UUB_DBITS_RST;
			stop_q  <= UUB_STOP_1;
			par_q   <= UUB_PAR_NONE;
			flow_q  <= UUB_FLOW_NONE;
			dtr_q   <= 1'b0;
			baud_q  <= 5'(BAUD_INIT);
		end
		else if (CE_I & ~fmt_bad)
		begin
			if (wr & off == UUB_OFF_CTRL)
			begin
				dbits_q <= PWDATA_I[UUB_DBITS_LSB +: 2];
				stop_q  <= PWDATA_I[UUB_STOP_LSB +: 2];
				par_q   <= PWDATA_I[UUB_PAR_LSB +: 3];
				flow_q  <= PWDATA_I[UUB_FLOW_LSB +: 2];
				dtr_q   <= PWDATA_I[UUB_DTR_BIT];
			end
			if (wr & off == UUB_OFF_BAUD)
				baud_q <= PWDATA_I[4:0];
		end
	end

	// descriptor store access and lock
	assign lock_bad = wr & off == UUB_OFF_DDATA & locked_q;
	assign dwr      = wr & off == UUB_OFF_DDATA & ~locked_q & desc_ok(daddr_q, PWDATA_I[15:0]);
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			daddr_q  <= 8'h00;
			locked_q <= 1'b0;
			prog_q   <= 1'b0;
		end
		else if (CE_I)
		begin
			if (wr & off == UUB_OFF_DADDR)
				daddr_q <= PWDATA_I[7:0];
			if (wr & off == UUB_OFF_LOCK & PWDATA_I[7:0] == UUB_LOCK_KEY)
				locked_q <= 1'b1;
			if (dwr)
				prog_q <= 1'b1;
		end
	end

	uub_desc_mem #(
		.AW (8),
		.DW (16)
	) u_mem (
		.clk_i     (REF_CLK_I),
		.ce_i      (CE_I),
		.wr_en_i   (dwr),
		.addr_i    (daddr_q),
		.wr_data_i (PWDATA_I[15:0]),
		.rd_data_o (mem_rd)
	);

	// sticky error flags, write one to clear, a new event wins
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			err_lock_q <= 1'b0;
			err_fmt_q  <= 1'b0;
			err_par_q  <= 1'b0;
			err_ovr_q  <= 1'b0;
		end
		else if (CE_I)
		begin
			err_lock_q <= lock_bad | (err_lock_q & ~(stat_wr & PWDATA_I[7]));
			err_fmt_q  <= fmt_bad | (err_fmt_q & ~(stat_wr & PWDATA_I[8]));
			err_par_q  <= par_bad | (err_par_q & ~(stat_wr & PWDATA_I[9]));
			err_ovr_q  <= ovr | (err_ovr_q & ~(stat_wr & PWDATA_I[10]));
		end
	end

	// configuration and suspend tracking
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			cfg_q  <= 1'b0;
			susp_q <= 1'b0;
		end
		else if (CE_I)
		begin
			if (USB_CONFIGURED_I)
				cfg_q <= 1'b1;
			if (USB_RESUME_I | USB_BUS_RESET_I)
				susp_q <= 1'b0;
			else if (USB_SUSPEND_DET_I)
				susp_q <= 1'b1;
		end
	end

	// complementary low-power indicators, asserted from reset on
	assign low_pwr = ~cfg_q | susp_q;
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			SUSPEND_O   <= 1'b1;
			SUSPEND_N_O <= 1'b0;
		end
		else if (CE_I)
		begin
			SUSPEND_O   <= low_pwr;
			SUSPEND_N_O <= ~low_pwr;
		end
	end

	// transmit hold-off per flow scheme
	assign hold = (flow_q == UUB_FLOW_RTS & CTS_N_I)
		| (flow_q == UUB_FLOW_DTR & DSR_N_I)
		| (flow_q == UUB_FLOW_XON & xoff_q);
	assign USB_OUT_READY_O = CE_I & tx_st_q == UUB_IDLE & ~hold & ~susp_q;
	assign tx_take         = USB_OUT_VALID_I & USB_OUT_READY_O;

	// transmit framer, each phase counted in half-bit steps
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			tx_st_q  <= UUB_IDLE;
			tx_sh_q  <= 8'h00;
			tx_par_q <= 1'b0;
			tx_bit_q <= 3'h0;
			tx_hlf_q <= 3'h0;
			tx_cnt_q <= '0;
		end
		else if (CE_I)
		begin
			if (tx_st_q == UUB_IDLE)
			begin
				if (tx_take)
				begin
					tx_st_q  <= UUB_START;
					tx_sh_q  <= USB_OUT_DATA_I;
					tx_par_q <= par_bit(USB_OUT_DATA_I, nbits, par_q);
					tx_bit_q <= 3'h0;
					tx_hlf_q <= 3'h1;
					tx_cnt_q <= half - 1'b1;
				end
			end
			else if (tx_cnt_q != '0)
				tx_cnt_q <= tx_cnt_q - 1'b1;
			else if (tx_hlf_q != 3'h0)
			begin
				tx_hlf_q <= tx_hlf_q - 3'h1;
				tx_cnt_q <= half - 1'b1;
			end
			else
			begin
				tx_cnt_q <= half - 1'b1;
				tx_hlf_q <= 3'h1;
				case (tx_st_q)
					UUB_START: tx_st_q <= UUB_DATA;
					UUB_DATA:
					begin
						tx_sh_q  <= tx_sh_q >> 1;
						tx_bit_q <= tx_bit_q + 3'h1;
						if ({1'b0, tx_bit_q} == nbits - 4'h1)
						begin
							tx_st_q <= (par_q == UUB_PAR_NONE) ? UUB_STOP : UUB_PAR;
							if (par_q == UUB_PAR_NONE)
								tx_hlf_q <= stop_halves - 3'h1;
						end
					end
					UUB_PAR:
					begin
						tx_st_q  <= UUB_STOP;
						tx_hlf_q <= stop_halves - 3'h1;
					end
					default: tx_st_q <= UUB_IDLE;
				endcase
			end
		end
	end

	// line level one cycle behind the framer state
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
			TXD_O <= 1'b1;
		else if (CE_I)
			TXD_O <= (tx_st_q == UUB_START) ? 1'b0 : (tx_st_q == UUB_DATA) ? tx_sh_q[0] :
				(tx_st_q == UUB_PAR) ? tx_par_q : 1'b1;
	end

	// receive framer, samples each bit at its middle
	assign rx_end = rx_st_q == UUB_STOP & rx_cnt_q == '0 & rx_hlf_q == 3'h0;
	assign rx_byte = rx_sh_q >> (4'h8 - nbits);
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			rx_st_q  <= UUB_IDLE;
			rx_sh_q  <= 8'h00;
			rx_bit_q <= 3'h0;
			rx_hlf_q <= 3'h0;
			rx_cnt_q <= '0;
		end
		else if (CE_I)
		begin
			if (rx_st_q == UUB_IDLE)
			begin
				if (~RXD_I)
				begin
					rx_st_q  <= UUB_START;
					rx_bit_q <= 3'h0;
					rx_hlf_q <= 3'h0;
					rx_cnt_q <= half - 1'b1;
				end
			end
			else if (rx_cnt_q != '0)
				rx_cnt_q <= rx_cnt_q - 1'b1;
			else if (rx_hlf_q != 3'h0)
			begin
				rx_hlf_q <= rx_hlf_q - 3'h1;
				rx_cnt_q <= half - 1'b1;
			end
			else
			begin
				rx_cnt_q <= half - 1'b1;
				rx_hlf_q <= 3'h1;
				case (rx_st_q)
					UUB_START: rx_st_q <= RXD_I ? UUB_IDLE : UUB_DATA;
					UUB_DATA:
					begin
						rx_sh_q  <= {RXD_I, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if ({1'b0, rx_bit_q} == nbits - 4'h1)
							rx_st_q <= (par_q == UUB_PAR_NONE) ? UUB_STOP : UUB_PAR;
					end
					UUB_PAR: rx_st_q <= UUB_STOP;
					default: rx_st_q <= UUB_IDLE;
				endcase
			end
		end
	end

	// received byte: flow codes act, others go to usb
	assign par_bad    = CE_I & rx_st_q == UUB_PAR & rx_cnt_q == '0 & rx_hlf_q == 3'h0
		& RXD_I != par_bit(rx_byte, nbits, par_q);
	assign rx_ctl     = flow_q == UUB_FLOW_XON & (rx_byte == UUB_XON | rx_byte == UUB_XOFF);
	assign rx_deliver = CE_I & rx_end & RXD_I & ~rx_ctl;
	assign ovr        = rx_deliver & rx_full_q & ~USB_IN_READY_I;
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
		begin
			rx_full_q <= 1'b0;
			rx_data_q <= 8'h00;
			xoff_q    <= 1'b0;
		end
		else if (CE_I)
		begin
			if (rx_end & RXD_I & rx_ctl)
				xoff_q <= rx_byte == UUB_XOFF;
			else if (flow_q != UUB_FLOW_XON)
				xoff_q <= 1'b0;
			if (rx_deliver & ~ovr)
			begin
				rx_full_q <= 1'b1;
				rx_data_q <= rx_byte;
			end
			else if (USB_IN_READY_I)
				rx_full_q <= 1'b0;
		end
	end
	assign USB_IN_DATA_O  = rx_data_q;
	assign USB_IN_VALID_O = rx_full_q;

	// modem outputs, active low
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
			RTS_N_O <= 1'b1;
		else if (CE_I)
			RTS_N_O <= (flow_q == UUB_FLOW_RTS) & (rx_full_q | rx_st_q == UUB_STOP);
	end
	assign DTR_N_O = ~dtr_q;
endmodule
`default_nettype wire

// [tb/uub_bridge_assertions.sv]
// checker: assertions on the bridge ports
`default_nettype none
module uub_bridge_chk
(
	input wire logic       REF_CLK_I,
	input wire logic       SYS_RST_I,
	input wire logic       CE_I,
	input wire logic       PSEL_I,
	input wire logic       PENABLE_I,
	input wire logic       PWRITE_I,
	input wire logic       PREADY_O,
	input wire logic       USB_SUSPEND_DET_I,
	input wire logic       USB_RESUME_I,
	input wire logic       USB_BUS_RESET_I,
	input wire logic       USB_CONFIGURED_I,
	input wire logic       USB_OUT_VALID_I,
	input wire logic       USB_OUT_READY_O,
	input wire logic [7:0] USB_IN_DATA_O,
	input wire logic       USB_IN_VALID_O,
	input wire logic       USB_IN_READY_I,
	input wire logic       TXD_O,
	input wire logic       SUSPEND_O,
	input wire logic       SUSPEND_N_O
);
	timeunit 1ns;
	timeprecision 1ps;
	logic cfg_q;
	// enumeration seen since reset
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I)
	begin
		if (SYS_RST_I)
			cfg_q <= 1'h0;
		else if (CE_I && USB_CONFIGURED_I)
			cfg_q <= 1'h1;
	end
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I || !CE_I);
	property p_comp; SUSPEND_O != SUSPEND_N_O; endproperty
	a_comp: assert property (p_comp) else $error("indicators not inverse");
	property p_enter;
		USB_SUSPEND_DET_I && !USB_RESUME_I && !USB_BUS_RESET_I |-> ##2 SUSPEND_O && !SUSPEND_N_O;
	endproperty
	a_enter: assert property (p_enter) else $error("suspend not entered");
	property p_exit; cfg_q && (USB_RESUME_I || USB_BUS_RESET_I) |-> ##2 !SUSPEND_O; endproperty
	a_exit: assert property (p_exit) else $error("suspend not left");
	property p_cfg; !cfg_q |-> SUSPEND_O; endproperty
	a_cfg: assert property (p_cfg) else $error("indicator dropped early");
	property p_start; USB_OUT_VALID_I && USB_OUT_READY_O |-> ##2 !TXD_O [*8]; endproperty
	a_start: assert property (p_start) else $error("start bit missing");
	property p_wr; PSEL_I && PENABLE_I && PWRITE_I |-> PREADY_O; endproperty
	a_wr: assert property (p_wr) else $error("write not answered");
	property p_rd; PSEL_I && $rose(PENABLE_I) && !PWRITE_I |-> !PREADY_O ##1 PREADY_O; endproperty
	a_rd: assert property (p_rd) else $error("read wait wrong");
	property p_hold;
		USB_IN_VALID_O && !USB_IN_READY_I |=> USB_IN_VALID_O && $stable(USB_IN_DATA_O);
	endproperty
	a_hold: assert property (p_hold) else $error("received byte lost");
endmodule
bind uub_bridge uub_bridge_chk i_uub_bridge_chk (.*);
`default_nettype wire

// [tb/uub_serial_peer.sv]
// partner model: serial peer on the link
`default_nettype none
module uub_serial_peer
#(
	parameter int unsigned BIT = 54
)
(
	input  wire logic clk_i,
	input  wire logic txd_i,
	output var logic  rxd_o,
	output var logic  cts_n_o,
	output var logic  dsr_n_o,
	output var logic  dcd_n_o,
	output var logic  ri_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] rx_q;
	int         rx_cnt;
	// idle line high, modem lines asserted (low)
	initial
	begin
		rxd_o = 1'h1;
		{cts_n_o, dsr_n_o, dcd_n_o, ri_n_o} = 4'h0;
		rx_cnt = 0;
	end
	// sends one 8N1 frame, lsb first
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_i) rxd_o <= f[i];
			repeat (BIT - 1) @(posedge clk_i);
		end
	endtask
	// decodes ten mid-bit slots per frame
	always
	begin
		@(negedge txd_i);
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 10; i++)
		begin
			if (i > 0)
				repeat (BIT) @(posedge clk_i);
			rx_q[i] = txd_i;
		end
		rx_cnt++;
	end
endmodule
`default_nettype wire

// [tb/uub_bridge_tb.sv]
// testbench of the bridge control
`default_nettype none
module uub_bridge_tb
	import uub_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] PBIT = 5'h0D; // bit after 7 data bits per parity code
	logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	logic        ov = 1'h0, ir = 1'h0, lerr;
	logic [3:0]  ev = 4'h0;
	logic [7:0]  pa = 8'h00, od = 8'h00, idat;
	logic [31:0] pwd = 32'h0, prd, rdat;
	logic        pready, slverr, ordy, ivld, txd, rxd, sus, sus_n;
	logic        cts_n, rts_n, dsr_n, dtr_n, dcd_n, ri_n;
	int          mismatches = 0, total_checks = 0;
	// 50 MHz clock
	always #10 clk = ~clk;
	// bridge and its serial peer
	uub_bridge i_uub_bridge
	(
		.REF_CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'h1), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I({4'h0, pa}), .PWDATA_I(pwd), .PRDATA_O(prd),
		.PREADY_O(pready), .PSLVERR_O(slverr), .USB_SUSPEND_DET_I(ev[3]),
		.USB_RESUME_I(ev[2]), .USB_BUS_RESET_I(ev[1]), .USB_CONFIGURED_I(ev[0]),
		.USB_OUT_DATA_I(od), .USB_OUT_VALID_I(ov), .USB_OUT_READY_O(ordy),
		.USB_IN_DATA_O(idat), .USB_IN_VALID_O(ivld), .USB_IN_READY_I(ir), .TXD_O(txd),
		.RXD_I(rxd), .CTS_N_I(cts_n), .RTS_N_O(rts_n), .DSR_N_I(dsr_n), .DTR_N_O(dtr_n),
		.DCD_N_I(dcd_n), .RI_N_I(ri_n), .SUSPEND_O(sus), .SUSPEND_N_O(sus_n)
	);
	uub_serial_peer i_uub_serial_peer
	(
		.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
		.dcd_n_o(dcd_n), .ri_n_o(ri_n)
	);
	// prints counts and the verdict, then stops
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// one counted comparison
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) {psel, pen, pwr, pa, pwd} <= {1'h1, 1'h0, w, a, d};
		@(posedge clk) pen <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rdat = prd;
		lerr = slverr;
		{psel, pen} <= 2'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'h0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	task automatic drd(input logic [7:0] a, input logic [15:0] e);
		apb(1'h1, UUB_OFF_DADDR, {24'h0, a});
		rd(UUB_OFF_DDATA, {16'h0, e}, "descriptor");
	endtask
	// usb event pulse, then indicator check
	task automatic ev_pulse(input logic [3:0] v, input logic e);
		@(posedge clk) ev <= v;
		@(posedge clk) ev <= 4'h0;
		repeat (2) @(posedge clk);
		chk("indicators", {30'h0, e, ~e}, {30'h0, sus, sus_n});
	endtask
	// hands one byte to the transmit side
	task automatic usb_tx(input logic [7:0] b);
		@(posedge clk) {ov, od} <= {1'h1, b};
		do @(posedge clk); while (ordy !== 1'h1);
		ov <= 1'h0;
	endtask
	task automatic t_reset();
		chk("reset indicators", 32'h2, {30'h0, sus, sus_n});
		chk("reset modem outs", 32'h3, {30'h0, rts_n, dtr_n});
		rd(UUB_OFF_CTRL, 32'h3, "ctrl");
		rd(UUB_OFF_BAUD, 32'h8, "baud");
		rd(UUB_OFF_MODEM, 32'hF, "modem");
		drd(UUB_DESC_PWR_ATTR, 16'h80);
		drd(UUB_DESC_MAX_PWR, 16'h32);
		drd(UUB_DESC_RELEASE, 16'h100);
		drd(UUB_DESC_SER_LEN, 16'h4);
		for (int i = 0; i < 4; i++)
			drd(UUB_DESC_SER_BASE + 8'(i), (i == 3) ? 16'h31 : 16'h30);
	endtask
	task automatic t_susp();
		ev_pulse(4'h4, 1'h1);
		ev_pulse(4'h1, 1'h0);
		ev_pulse(4'h8, 1'h1);
		ev_pulse(4'h4, 1'h0);
		ev_pulse(4'h8, 1'h1);
		ev_pulse(4'h2, 1'h0);
		ev_pulse(4'hC, 1'h0);
	endtask
	task automatic t_tx();
		apb(1'h1, UUB_OFF_BAUD, 32'h1C);
		usb_tx(8'hA5);
		do @(posedge clk); while (i_uub_serial_peer.rx_cnt != 1);
		chk("frame", 32'h34A, {22'h0, i_uub_serial_peer.rx_q});
		for (int p = 0; p < 5; p++)
		begin
			apb(1'h1, UUB_OFF_CTRL, (32'(p) << 4) | 32'h2);
			usb_tx(8'h15);
			do @(posedge clk); while (i_uub_serial_peer.rx_cnt != p + 2);
			chk("parity frame", {23'h0, PBIT[p], 8'h2A}, {23'h0, i_uub_serial_peer.rx_q[8:0]});
		end
	endtask
	task automatic t_fmt();
		apb(1'h1, UUB_OFF_CTRL, 32'h7);
		apb(1'h1, UUB_OFF_CTRL, 32'h0);
		apb(1'h1, UUB_OFF_BAUD, 32'h1D);
		rd(UUB_OFF_CTRL, 32'h42, "ctrl kept");
		rd(UUB_OFF_BAUD, 32'h1C, "baud kept");
		apb(1'h0, UUB_OFF_STAT, 32'h0);
		chk("format error", 32'h1, {31'h0, rdat[8]});
		apb(1'h1, UUB_OFF_BAUD, 32'h1B);
		apb(1'h1, UUB_OFF_CTRL, 32'h4);
		rd(UUB_OFF_CTRL, 32'h4, "five bits 1.5 stop");
		apb(1'h1, UUB_OFF_CTRL, 32'h203);
		apb(1'h1, UUB_OFF_BAUD, 32'h1C);
		chk("dtr", 32'h0, {31'h0, dtr_n});
	endtask
	task automatic t_rx();
		i_uub_serial_peer.send(8'h5A);
		do @(posedge clk); while (ivld !== 1'h1);
		chk("rx byte", 32'h5A, {24'h0, idat});
		@(posedge clk) ir <= 1'h1;
		@(posedge clk) ir <= 1'h0;
		apb(1'h1, UUB_OFF_CTRL, 32'h183);
		i_uub_serial_peer.send(8'h13);
		repeat (4) @(posedge clk);
		chk("xoff hold", 32'h0, {30'h0, ordy, ivld});
		i_uub_serial_peer.send(8'h11);
		repeat (4) @(posedge clk);
		chk("xon resume", 32'h2, {30'h0, ordy, ivld});
		for (int f = 1; f < 3; f++)
		begin
			apb(1'h1, UUB_OFF_CTRL, (32'(f) << 7) | 32'h3);
			{i_uub_serial_peer.dsr_n_o, i_uub_serial_peer.cts_n_o} <= 2'(f);
			repeat (2) @(posedge clk);
			chk("held", 32'h0, {31'h0, ordy});
			{i_uub_serial_peer.dsr_n_o, i_uub_serial_peer.cts_n_o} <= 2'h0;
			repeat (2) @(posedge clk);
			chk("released", 32'h1, {31'h0, ordy});
		end
		apb(1'h1, UUB_OFF_CTRL, 32'h83);
		chk("rts open", 32'h0, {31'h0, rts_n});
		i_uub_serial_peer.send(8'h33);
		do @(posedge clk); while (ivld !== 1'h1);
		@(posedge clk);
		chk("rts full", 32'h1, {31'h0, rts_n});
		@(posedge clk) ir <= 1'h1;
		@(posedge clk) ir <= 1'h0;
	endtask
	task automatic t_desc();
		apb(1'h1, UUB_OFF_DADDR, {24'h0, UUB_DESC_SER_LEN});
		apb(1'h1, UUB_OFF_DDATA, 32'h40);
		drd(UUB_DESC_SER_LEN, 16'h4);
		apb(1'h1, UUB_OFF_DDATA, 32'h3F);
		drd(UUB_DESC_SER_LEN, 16'h3F);
		apb(1'h1, UUB_OFF_LOCK, 32'hA5);
		apb(1'h1, UUB_OFF_DDATA, 32'h1);
		drd(UUB_DESC_SER_LEN, 16'h3F);
		apb(1'h0, UUB_OFF_STAT, 32'h0);
		chk("lock flags", 32'h3, {30'h0, rdat[7], rdat[2]});
		apb(1'h0, 8'h1C, 32'h0);
		chk("unmapped", 32'h1, {rdat[30:0], lerr});
	endtask
	// main sequence after the reset hold
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_susp();
		t_tx();
		t_fmt();
		t_rx();
		t_desc();
		tally_and_finish();
	end
	// watchdog against a hung handshake
	initial
	begin
		repeat (40000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
